// File: common/bfs_pkg.sv
// Constants and types for the fault supervisor and config block
package bfs_pkg;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_VOUT = 8'h04;
  localparam logic [7:0] A_CFG = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  // Control register fields
  localparam int CTRL_HOT_LSB = 0;
  localparam int CTRL_OT_LSB = 8;
  localparam int CTRL_OC_LSB = 16;
  // Config register fields
  localparam int CFG_VC_LSB = 0;
  localparam int CFG_MODE_LSB = 8;
  localparam int CFG_PH_LSB = 12;
  localparam int VC_FREQ_LSB = 4;
  // Reset values and hysteresis, degrees C for temperatures
  localparam logic [7:0] HOT_RST = 8'h6e;
  localparam logic [7:0] OT_RST = 8'h7d;
  localparam logic [8:0] OT_HYS = 9'h00f;
  localparam logic [8:0] OC_RST = 9'h1ff;
  localparam logic [2:0] PH_MAX = 3'h4;
  // Hiccup delay
  localparam int HICCUP_US = 22000;
  localparam int CLK_MHZ = 200;
  localparam int HICCUP_CYC = HICCUP_US * CLK_MHZ;
  localparam int HIC_W = 23;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_HICCUP,
    ST_OV,
    ST_OT
  } bfs_state_t;

  // Strap and nonvolatile inputs
  typedef struct packed {
    logic src_nvm;
    logic [2:0] phase_tied;
    logic [6:0] startup_voltage_hi;
    logic addr_lsb;
    logic [3:0] pmbus_addr;
    logic [3:0] mode;
    logic [2:0] freq;
    logic [7:0] maxload;
    logic [3:0] nvm_freq;
    logic [7:0] nvm_startup_voltage;
    logic [3:0] nvm_mode;
    logic [7:0] nvm_maxload;
  } bfs_straps_t;

  typedef struct packed {
    bfs_state_t st;
    logic uvlo;
    logic pb_latch;
    logic aux3_prev;
    logic [HIC_W-1:0] hic_cnt;
    logic [7:0] hot_thr;
    logic [7:0] ot_thr;
    logic [8:0] oc_thr;
    logic [7:0] vout_cmd;
    logic [7:0] startup;
    logic [7:0] vcfg12;
    logic [3:0] mode;
    logic [2:0] phases;
    logic [3:0] pm_addr;
    logic src_nvm;
    logic [3:0] pwm_hi;
    logic [3:0] pwm_oe_n;
    logic ready;
    logic warn_n;
    logic fault_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bfs_st_t;
endpackage

// File: src/bfs_top.sv
// Fault supervisor, PWM gating and power-up config latch
// Overview of operation
// - Aux 5 V lockout with hysteresis restart
// - Undervoltage tri-states every PWM output
// - Undervoltage hiccup wait, restart, repeat
// - Tracking overvoltage: ready low, PWM low
// - Tracking check blanked during DAC change
// - Fixed overvoltage latched until enable/aux cycle
// - Pre-bias overvoltage latched until aux cycle
// - Valley limit withholds phase on-pulse
// - Average overcurrent: switches off, hiccup
// - Overtemperature off, restart after hysteresis
// - Hot warning pin low above threshold
// - Hot threshold set only by bus
// - Severe fault pin on listed faults
// - Phase count from tied sense inputs
// - Phase count captured at 3.3 V power-up
// - Config source: straps or nonvolatile
// - Bus address from strap only
// - Latched phases, mode, config byte and overcurrent level overwritable over bus
// - Strap 3-bit, memory 4-bit frequency
// - Startup code: 7 strap bits plus LSB
// - Regulate startup voltage until command
// - Mode bits decoded from mode strap
// - PWM high, low or tri-state
module bfs_top
#(
  parameter int HICCUP_CYCLES = bfs_pkg::HICCUP_CYC
)
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  // Supplies and enable
  input wire logic AUX5V_BELOW_LOW,
  input wire logic AUX5V_ABOVE_HIGH,
  input wire logic AUX3V3_GOOD,
  input wire logic VIN_OK,
  input wire logic ENABLE,
  // Output voltage comparators
  input wire logic UV_TRACK,
  input wire logic OV_TRACK,
  input wire logic OV_FIXED,
  input wire logic OV_PREBIAS,
  input wire logic DAC_CHANGING,
  // Current and temperature
  input wire logic [3:0] VALLEY_OVER,
  input wire logic [7:0] CURRENT_MONITOR_INPUT_CODE,
  input wire logic [7:0] TEMP_CODE,
  input wire logic STAGE_FAULT,
  // Modulator requests
  input wire logic [3:0] PWM_REQ,
  // Straps and memory
  input wire bfs_pkg::bfs_straps_t STRAPS,
  // PWM pins
  output logic [3:0] PWM_HI,
  output logic [3:0] PWM_OE_N,
  // Status pins and settings
  output logic OUTPUT_READY,
  output logic THERMAL_WARN_N,
  output logic SEVERE_FAULT_N,
  output logic [3:0] PMBUS_ADDR,
  output logic [7:0] VOUT_TARGET,
  output logic [3:0] OP_MODE,
  output logic [7:0] VENDOR_CFG12
);
  import bfs_pkg::*;

  localparam logic [HIC_W-1:0] HIC_LAST = HIC_W'(HICCUP_CYCLES - 1);

  bfs_st_t s_reg;
  bfs_st_t s_next;
  logic run_ok;
  logic oc_now;
  logic ot_now;
  logic ot_clear;
  logic ov_trk;
  logic force_low;
  logic latch_cfg;
  logic wr;
  logic [2:0] ph_strap;
  logic [8:0] oc_dflt;
  logic [7:0] maxload;
  logic [3:0] pwm_hi_d;
  logic [3:0] pwm_oe_n_d;

  // Supply qualification
  assign run_ok = !s_reg.uvlo && VIN_OK && ENABLE && !s_reg.pb_latch;
  assign ov_trk = OV_TRACK && !DAC_CHANGING;
  assign oc_now = {1'b0, CURRENT_MONITOR_INPUT_CODE} > s_reg.oc_thr;
  assign ot_now = TEMP_CODE > s_reg.ot_thr;
  assign ot_clear = ({1'b0, TEMP_CODE} + OT_HYS) <= {1'b0, s_reg.ot_thr};
  assign force_low = (s_reg.st == ST_OV) || s_reg.pb_latch;
  assign latch_cfg = AUX3V3_GOOD && !s_reg.aux3_prev;
  assign wr = PSEL && PENABLE && s_reg.pready && PWRITE;

  // Phase count from tied sense inputs
  always_comb
  begin
    if (STRAPS.phase_tied[0])
    begin
      ph_strap = 3'h1;
    end
    else if (STRAPS.phase_tied[1])
    begin
      ph_strap = 3'h2;
    end
    else if (STRAPS.phase_tied[2])
    begin
      ph_strap = 3'h3;
    end
    else
    begin
      ph_strap = PH_MAX;
    end
  end

  // Default overcurrent level is 1.25 times max load
  assign maxload = STRAPS.src_nvm ? STRAPS.nvm_maxload : STRAPS.maxload;
  assign oc_dflt = {1'b0, maxload} + {3'h0, maxload[7:2]};

  // Per-phase PWM drive
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ph
      logic ph_on;
      assign ph_on = (3'(gi) < s_reg.phases) && (s_reg.st == ST_RUN);
      always_comb
      begin
        if (force_low)
        begin
          pwm_hi_d[gi] = 1'b0;
          pwm_oe_n_d[gi] = 1'b0;
        end
        else if (ph_on)
        begin
          pwm_hi_d[gi] = PWM_REQ[gi] && !VALLEY_OVER[gi];
          pwm_oe_n_d[gi] = 1'b0;
        end
        else
        begin
          pwm_hi_d[gi] = 1'b0;
          pwm_oe_n_d[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // Next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.aux3_prev = AUX3V3_GOOD;
    // Aux 5 V lockout
    if (AUX5V_BELOW_LOW)
    begin
      s_next.uvlo = 1'b1;
    end
    else if (AUX5V_ABOVE_HIGH && VIN_OK && ENABLE)
    begin
      s_next.uvlo = 1'b0;
    end
    // Pre-bias latch, a new detection beats the aux clear
    if (!ENABLE && OV_PREBIAS)
    begin
      s_next.pb_latch = 1'b1;
    end
    else if (AUX5V_BELOW_LOW)
    begin
      s_next.pb_latch = 1'b0;
    end
    // Protection sequencer
    case (s_reg.st)
      ST_OFF:
      begin
        if (run_ok)
        begin
          s_next.st = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!run_ok)
        begin
          s_next.st = ST_OFF;
        end
        else if (OV_FIXED || ov_trk)
        begin
          s_next.st = ST_OV;
        end
        else if (ot_now)
        begin
          s_next.st = ST_OT;
        end
        else if (oc_now || UV_TRACK)
        begin
          s_next.st = ST_HICCUP;
          s_next.hic_cnt = '0;
        end
      end
      ST_HICCUP:
      begin
        if (!run_ok)
        begin
          s_next.st = ST_OFF;
        end
        else if (s_reg.hic_cnt != HIC_LAST)
        begin
          s_next.hic_cnt = s_reg.hic_cnt + 1'b1;
        end
        else if (!oc_now)
        begin
          s_next.st = ST_RUN;
          s_next.vout_cmd = s_reg.startup;
        end
      end
      ST_OV:
      begin
        if (!ENABLE || s_reg.uvlo)
        begin
          s_next.st = ST_OFF;
        end
      end
      ST_OT:
      begin
        if (!run_ok)
        begin
          s_next.st = ST_OFF;
        end
        else if (ot_clear)
        begin
          s_next.st = ST_RUN;
          s_next.vout_cmd = s_reg.startup;
        end
      end
      default:
      begin
        s_next.st = ST_OFF;
      end
    endcase
    // Bus writes
    if (wr)
    begin
      case (PADDR)
        A_CTRL:
        begin
          s_next.hot_thr = PWDATA[CTRL_HOT_LSB +: 8];
          s_next.ot_thr = PWDATA[CTRL_OT_LSB +: 8];
          s_next.oc_thr = PWDATA[CTRL_OC_LSB +: 9];
        end
        A_VOUT:
        begin
          s_next.vout_cmd = PWDATA[7:0];
        end
        A_CFG:
        begin
          s_next.vcfg12 = PWDATA[CFG_VC_LSB +: 8];
          s_next.mode = PWDATA[CFG_MODE_LSB +: 4];
          s_next.phases = PWDATA[CFG_PH_LSB +: 3];
        end
        default:
        begin
        end
      endcase
    end
    // Power-up config capture
    if (latch_cfg)
    begin
      s_next.src_nvm = STRAPS.src_nvm;
      s_next.phases = ph_strap;
      s_next.pm_addr = STRAPS.pmbus_addr;
      s_next.oc_thr = oc_dflt;
      if (STRAPS.src_nvm)
      begin
        s_next.vcfg12 = {STRAPS.nvm_freq, 4'h0};
        s_next.startup = STRAPS.nvm_startup_voltage;
        s_next.mode = STRAPS.nvm_mode;
      end
      else
      begin
        s_next.vcfg12 = 8'(STRAPS.freq) << VC_FREQ_LSB;
        s_next.startup = {STRAPS.startup_voltage_hi, STRAPS.addr_lsb};
        s_next.mode = STRAPS.mode;
      end
      s_next.vout_cmd = s_next.startup;
    end
    // Pins
    s_next.pwm_hi = pwm_hi_d;
    s_next.pwm_oe_n = pwm_oe_n_d;
    s_next.ready = (s_reg.st == ST_RUN) && !ov_trk && !OV_FIXED;
    s_next.warn_n = !(TEMP_CODE > s_reg.hot_thr);
    s_next.fault_n = !(oc_now || ot_now || STAGE_FAULT || force_low
                       || OV_FIXED || ov_trk);
    // Bus answer, zero wait states
    s_next.pready = PSEL && !PENABLE;
    s_next.pslverr = 1'b0;
    s_next.prdata = '0;
    if (PSEL && !PENABLE)
    begin
      case (PADDR)
        A_CTRL:
        begin
          s_next.prdata = {7'h0, s_reg.oc_thr, s_reg.ot_thr, s_reg.hot_thr};
        end
        A_VOUT:
        begin
          s_next.prdata = {24'h0, s_reg.vout_cmd};
        end
        A_CFG:
        begin
          s_next.prdata = {17'h0, s_reg.phases, s_reg.mode, s_reg.vcfg12};
        end
        A_STAT:
        begin
          s_next.prdata = {10'h0, s_reg.startup, s_reg.pm_addr, 1'b0,
                           s_reg.src_nvm, !s_reg.fault_n, !s_reg.warn_n,
                           s_reg.ready, s_reg.pb_latch, s_reg.uvlo, s_reg.st};
        end
        default:
        begin
          s_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      s_reg <= '0;
      s_reg.st <= ST_OFF;
      s_reg.uvlo <= 1'b1;
      s_reg.hot_thr <= HOT_RST;
      s_reg.ot_thr <= OT_RST;
      s_reg.oc_thr <= OC_RST;
      s_reg.phases <= PH_MAX;
      s_reg.pwm_oe_n <= 4'hf;
      s_reg.warn_n <= 1'b1;
      s_reg.fault_n <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign PRDATA = s_reg.prdata;
  assign PWM_HI = s_reg.pwm_hi;
  assign PWM_OE_N = s_reg.pwm_oe_n;
  assign OUTPUT_READY = s_reg.ready;
  assign THERMAL_WARN_N = s_reg.warn_n;
  assign SEVERE_FAULT_N = s_reg.fault_n;
  assign PMBUS_ADDR = s_reg.pm_addr;
  assign VOUT_TARGET = s_reg.vout_cmd;
  assign OP_MODE = s_reg.mode;
  assign VENDOR_CFG12 = s_reg.vcfg12;
endmodule

// File: bench/bfs_stage_model.sv
// Power stage and load model
module bfs_stage_model
(
  input logic clk,
  input logic [3:0] hi, oe_n,
  input logic [7:0] t_set,
  input logic bad, heavy,
  output logic [7:0] t_code,
  output logic fault,
  output logic [3:0] valley
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    t_code = 8'h19;
    fault = 1'h0;
    valley = 4'h0;
  end
  // Hottest stage reading saturates
  always @(posedge clk)
  begin
    t_code <= t_set > 8'h7f ? 8'h7f : t_set;
    fault <= bad;
    valley <= heavy ? hi & ~oe_n : 4'h0;
  end
endmodule

// File: bench/bfs_top_monitor.sv
// Port checker for the fault supervisor
module bfs_top_monitor
(
  input logic CORE_CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY,
  input logic [7:0] PADDR, TEMP_CODE,
  input logic [31:0] PWDATA,
  input logic AUX5V_BELOW_LOW, ENABLE, UV_TRACK, OV_TRACK, OV_FIXED, OV_PREBIAS,
  input logic [3:0] VALLEY_OVER, PWM_HI, PWM_OE_N, PMBUS_ADDR,
  input bfs_pkg::bfs_straps_t STRAPS,
  input logic OUTPUT_READY, THERMAL_WARN_N, SEVERE_FAULT_N
);
  timeunit 1ns;
  timeprecision 100ps;
  import bfs_pkg::*;
  logic [7:0] hot, ot;
  // Shadow of bus-written thresholds
  always_ff @(posedge CORE_CLK)
    if (!RESET_N)
    begin
      hot <= HOT_RST;
      ot <= OT_RST;
    end
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == A_CTRL)
    begin
      hot <= PWDATA[CTRL_HOT_LSB +: 8];
      ot <= PWDATA[CTRL_OT_LSB +: 8];
    end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);
  property p_warn;
    TEMP_CODE > hot |=> !THERMAL_WARN_N;
  endproperty
  a_warn: assert property (p_warn) else $error("warn pin not low");
  property p_otf;
    TEMP_CODE > ot |=> !SEVERE_FAULT_N;
  endproperty
  a_otf: assert property (p_otf) else $error("no fault on overtemp");
  property p_ovf;
    OV_FIXED |=> !SEVERE_FAULT_N && !OUTPUT_READY;
  endproperty
  a_ovf: assert property (p_ovf) else $error("fixed overvoltage missed");
  property p_uv;
    UV_TRACK && OUTPUT_READY && ENABLE && !OV_FIXED && !OV_TRACK && !OV_PREBIAS
      |-> ##[1:2] PWM_OE_N == 4'hf;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not tri-stated");
  property p_pb;
    !ENABLE && OV_PREBIAS |-> ##[1:2] PWM_OE_N == 4'h0 && PWM_HI == 4'h0;
  endproperty
  a_pb: assert property (p_pb) else $error("prebias not driven low");
  property p_valley;
    VALLEY_OVER != 4'h0 |=> (PWM_HI & $past(VALLEY_OVER)) == 4'h0;
  endproperty
  a_valley: assert property (p_valley) else $error("on pulse over limit");
  property p_lvl;
    (PWM_HI & PWM_OE_N) == 4'h0;
  endproperty
  a_lvl: assert property (p_lvl) else $error("high level while released");
  property p_aux;
    AUX5V_BELOW_LOW |-> ##[1:3] !OUTPUT_READY;
  endproperty
  a_aux: assert property (p_aux) else $error("ready during aux lockout");
  property p_addr;
    $changed(PMBUS_ADDR) |-> PMBUS_ADDR == $past(STRAPS.pmbus_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address not from strap");
  c_uv: cover property (UV_TRACK && OUTPUT_READY);
  c_pb: cover property (!ENABLE && OV_PREBIAS);
  c_vl: cover property (VALLEY_OVER != 4'h0);
endmodule
bind bfs_top bfs_top_monitor mon_u (.*);

// File: bench/bfs_top_tb_top.sv
// Self-checking bench for the fault supervisor
module bfs_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import bfs_pkg::*;
  localparam int HIC = 20;
  localparam int SW = $bits(bfs_straps_t);
  logic CORE_CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, er;
  logic [7:0] PADDR = '0, CURRENT_MONITOR_INPUT_CODE = '0, TEMP_CODE, t_set = 8'h19, VOUT_TARGET, VENDOR_CFG12;
  logic [31:0] PWDATA = '0, PRDATA, rd, e, b;
  logic AUX5V_BELOW_LOW = 0, AUX5V_ABOVE_HIGH = 1, AUX3V3_GOOD = 1, VIN_OK = 1, ENABLE = 1;
  logic UV_TRACK = 0, OV_TRACK = 0, OV_FIXED = 0, OV_PREBIAS = 0, DAC_CHANGING = 0;
  logic STAGE_FAULT, bad = 0, heavy = 0, OUTPUT_READY, THERMAL_WARN_N, SEVERE_FAULT_N;
  logic [3:0] VALLEY_OVER, PWM_REQ = '0, PWM_HI, PWM_OE_N, PMBUS_ADDR, OP_MODE;
  bfs_straps_t STRAPS = '0, s;
  int n_mismatch = 0, n_tests = 0, cnt, cyc = 0, seed = 32'hf2512b41;
  bfs_top #(.HICCUP_CYCLES(HIC)) dut_u (.*);
  bfs_stage_model stg_u (.clk(CORE_CLK), .hi(PWM_HI), .oe_n(PWM_OE_N), .t_set(t_set),
    .bad(bad), .heavy(heavy), .t_code(TEMP_CODE), .fault(STAGE_FAULT), .valley(VALLEY_OVER));
  always #2.5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
  begin
    PWM_REQ <= 4'($random(seed));
    if (++cyc == 5000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", n, x, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'h1)
      @(posedge CORE_CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    #1;
  endtask
  task wt(input logic v, input int hi);
    cnt = 0;
    while (OUTPUT_READY !== v && cnt++ < hi)
      tick(1);
    chk("ready", v, OUTPUT_READY);
  endtask
  task rst;
    @(posedge CORE_CLK) RESET_N <= 0;
    STRAPS <= s;
    tick(20);
    @(posedge CORE_CLK) RESET_N <= 1;
    tick(3);
  endtask
  task aux;
    @(posedge CORE_CLK) AUX5V_BELOW_LOW <= 1;
    AUX5V_ABOVE_HIGH <= 0;
    tick(3);
    @(posedge CORE_CLK) AUX5V_BELOW_LOW <= 0;
    tick(5);
    chk("lockout", 0, OUTPUT_READY);
    @(posedge CORE_CLK) AUX5V_ABOVE_HIGH <= 1;
    wt(1, 10);
  endtask
  function automatic logic [31:0] f_cfg(bfs_straps_t t);
    logic [2:0] p;
    p = t.phase_tied[0] ? 3'h1 : t.phase_tied[1] ? 3'h2 : t.phase_tied[2] ? 3'h3 : 3'h4;
    return {17'h0, p, t.src_nvm ? t.nvm_mode : t.mode,
      t.src_nvm ? t.nvm_freq : {1'h0, t.freq}, 4'h0};
  endfunction
  function automatic logic [31:0] f_boot(bfs_straps_t t);
    logic [7:0] m;
    m = t.src_nvm ? t.nvm_maxload : t.maxload;
    return {11'h0, 9'(m) + 9'(m >> 2), t.src_nvm ? t.nvm_startup_voltage : {t.startup_voltage_hi, t.addr_lsb},
      t.pmbus_addr};
  endfunction
  initial
  begin
    for (int k = 0; k < 4; k++)
    begin
      s = SW'({$random(seed), $random(seed)});
      s.src_nvm = k[0];
      s.phase_tied = k == 3 ? 3'h0 : 3'h1 << k;
      rst();
      e = f_cfg(s);
      b = f_boot(s);
      apb(0, A_CFG, '0);
      chk("cfg", e, rd);
      chk("pins", e[11:0], {OP_MODE, VENDOR_CFG12});
      apb(0, A_CTRL, '0);
      chk("boot", b, {11'h0, rd[24:16], VOUT_TARGET, PMBUS_ADDR});
      wt(1, 20);
      chk("phases", 4'(4'hf << e[14:12]), PWM_OE_N);
      s = SW'({$random(seed), $random(seed)});
      @(posedge CORE_CLK) STRAPS <= s;
      apb(0, A_CFG, '0);
      chk("held", e, rd);
      chk("addr", b[3:0], PMBUS_ADDR);
    end
    $display("config test done");
    apb(1, A_VOUT, 32'h5a);
    apb(0, A_VOUT, '0);
    chk("vout", 16'h5a5a, {rd[7:0], VOUT_TARGET});
    apb(1, A_CFG, 32'h49c3);
    chk("cfg wr", 12'h9c3, {OP_MODE, VENDOR_CFG12});
    apb(0, 8'h10, '0);
    chk("unmapped", 32'h80000000, {er, rd[30:0]});
    apb(1, A_CTRL, 32'h00647d64);
    @(posedge CORE_CLK) t_set <= 8'h69;
    tick(4);
    chk("warn", 1, {THERMAL_WARN_N, OUTPUT_READY});
    @(posedge CORE_CLK) t_set <= 8'h7e;
    wt(0, 5);
    chk("ot", 5'h0f, {SEVERE_FAULT_N, PWM_OE_N});
    @(posedge CORE_CLK) t_set <= 8'h6f;
    tick(10);
    chk("ot hys", 0, OUTPUT_READY);
    @(posedge CORE_CLK) t_set <= 8'h6e;
    wt(1, 8);
    chk("restart", b[11:4], VOUT_TARGET);
    @(posedge CORE_CLK) t_set <= 8'h19;
    $display("thermal test done");
    repeat (2)
    begin
      @(posedge CORE_CLK) UV_TRACK <= 1;
      @(posedge CORE_CLK) UV_TRACK <= 0;
      wt(0, 4);
      chk("uv", 4'hf, PWM_OE_N);
      wt(1, HIC + 8);
      chk("hiccup", 1, cnt >= HIC - 3);
    end
    @(posedge CORE_CLK) CURRENT_MONITOR_INPUT_CODE <= 8'h65;
    wt(0, 5);
    tick(3 * HIC);
    chk("oc hold", 0, OUTPUT_READY);
    @(posedge CORE_CLK) CURRENT_MONITOR_INPUT_CODE <= 8'h64;
    wt(1, HIC + 8);
    $display("hiccup test done");
    @(posedge CORE_CLK) DAC_CHANGING <= 1;
    OV_TRACK <= 1;
    tick(4);
    apb(0, A_STAT, '0);
    chk("blank", 1, rd[2:0]);
    @(posedge CORE_CLK) DAC_CHANGING <= 0;
    tick(4);
    @(posedge CORE_CLK) OV_TRACK <= 0;
    tick(4);
    apb(0, A_STAT, '0);
    chk("ov", 12'h600, {rd[2:0], PWM_HI, PWM_OE_N, OUTPUT_READY});
    @(posedge CORE_CLK) ENABLE <= 0;
    @(posedge CORE_CLK) ENABLE <= 1;
    wt(1, 10);
    @(posedge CORE_CLK) DAC_CHANGING <= 1;
    OV_FIXED <= 1;
    @(posedge CORE_CLK) OV_FIXED <= 0;
    tick(4);
    chk("fixed", 0, {PWM_HI, PWM_OE_N, OUTPUT_READY});
    @(posedge CORE_CLK) DAC_CHANGING <= 0;
    aux();
    @(posedge CORE_CLK) ENABLE <= 0;
    OV_PREBIAS <= 1;
    @(posedge CORE_CLK) OV_PREBIAS <= 0;
    @(posedge CORE_CLK) ENABLE <= 1;
    tick(10);
    chk("prebias", 0, {PWM_HI, PWM_OE_N, OUTPUT_READY, SEVERE_FAULT_N});
    aux();
    $display("overvoltage test done");
    @(posedge CORE_CLK) bad <= 1;
    heavy <= 1;
    tick(20);
    chk("stage", 0, SEVERE_FAULT_N);
    @(posedge CORE_CLK) bad <= 0;
    heavy <= 0;
    tick(3);
    $display("stage test done");
    @(posedge CORE_CLK) VIN_OK <= 0;
    wt(0, 5);
    @(posedge CORE_CLK) VIN_OK <= 1;
    wt(1, 10);
    s = SW'({$random(seed), $random(seed)});
    @(posedge CORE_CLK) AUX3V3_GOOD <= 0;
    STRAPS <= s;
    @(posedge CORE_CLK) AUX3V3_GOOD <= 1;
    tick(2);
    apb(0, A_CFG, '0);
    chk("relatch", f_cfg(s), rd);
    chk("reladdr", 32'(s.pmbus_addr), PMBUS_ADDR);
    $display("supply test done");
    test_done();
  end
endmodule
